// ===== hdl/iep_map.svh
// Register offsets, reset values and field layout of the interrupt enable/pending bank
// Functional notes
// RULE1: Writing one to a set-enable bit enables that line; zero leaves it alone.
// RULE2: Reading a set-enable word returns each line's enable state.
// RULE3: Writing one to a clear-enable bit disables that line; zero does nothing.
// RULE4: Reading a clear-enable word returns the same enable state.
// RULE5: All enable, pending, active, priority and trigger state resets to zero.
// RULE6: Set-enable words sit at 0x000/0x004, clear-enable at 0x080/0x084.
// RULE7: Set-pending words sit at 0x100/0x104, clear-pending at 0x180/0x184.
// RULE8: Active status words sit at 0x200 and 0x204.
// RULE9: Priority words start at 0x300; the last one sits at 0x33C.
// RULE10: Software trigger word sits at 0xE00 and raises an interrupt on write.
// RULE11: A disabled line still goes pending but never activates; active holds.
// RULE12: Pending set and cleared by writing ones; clearing leaves active alone.
// RULE13: Each line has an 8-bit priority; each word holds four lines.
// RULE14: Bit n of the low word is line n; of the high word, line 32+n.
// RULE15: Simultaneous set and clear touch only bits written as one.
`ifndef IEP_MAP_SVH
`define IEP_MAP_SVH
`define IEP_ADDR_W 12
`define IEP_OFF_SET_EN_LO 12'h000
`define IEP_OFF_SET_EN_HI 12'h004
`define IEP_OFF_CLR_EN_LO 12'h080
`define IEP_OFF_CLR_EN_HI 12'h084
`define IEP_OFF_SET_PEND_LO 12'h100
`define IEP_OFF_SET_PEND_HI 12'h104
`define IEP_OFF_CLR_PEND_LO 12'h180
`define IEP_OFF_CLR_PEND_HI 12'h184
`define IEP_OFF_ACTIVE_LO 12'h200
`define IEP_OFF_ACTIVE_HI 12'h204
`define IEP_OFF_PRIO_FIRST 12'h300
`define IEP_OFF_PRIO_LAST 12'h33c
`define IEP_OFF_SOFT_TRIG 12'he00
`define IEP_RESET_WORD 32'h0000_0000
`define IEP_PRIO_W 8
`define IEP_PRIO_PER_WORD 4
`define IEP_TRIG_ID_W 6
`endif

// ===== hdl/iep_pkg.sv
// Types shared by the interrupt enable/pending bank
package iep_pkg;
  typedef logic [31:0] iep_word_type;
  typedef logic [11:0] iep_addr_type;
  typedef enum logic [3:0] {
    IEP_REG_NONE = 4'h0,
    IEP_REG_SET_EN = 4'h1,
    IEP_REG_CLR_EN = 4'h2,
    IEP_REG_SET_PEND = 4'h3,
    IEP_REG_CLR_PEND = 4'h4,
    IEP_REG_ACTIVE = 4'h5,
    IEP_REG_PRIO = 4'h6,
    IEP_REG_TRIG = 4'h7
  } iep_region_type;
endpackage

// ===== hdl/iep_line.sv
// Enable, pending and active state of one interrupt line
`timescale 1ns/1ps
module iep_line (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic srcLevel,
  input wire logic enSet,
  input wire logic enClr,
  input wire logic pendSet,
  input wire logic pendClr,
  input wire logic activateReq,
  input wire logic exitReq,
  output logic enabled,
  output logic pending,
  output logic active,
  output logic activated
);
  logic en_r;
  logic en_nxt;
  logic pend_r;
  logic pend_nxt;
  logic act_r;
  logic act_nxt;
  logic take;
  logic pendRaise;

  assign take = activateReq & en_r & pend_r & ~act_r; // RULE11
  assign pendRaise = srcLevel | pendSet; // RULE11
  assign en_nxt = enSet ? 1'b1 : (enClr ? 1'b0 : en_r); // RULE15
  assign pend_nxt = pendRaise ? 1'b1 : ((pendClr | take) ? 1'b0 : pend_r); // RULE12
  assign act_nxt = take ? 1'b1 : (exitReq ? 1'b0 : act_r); // RULE11
  assign enabled = en_r;
  assign pending = pend_r;
  assign active = act_r;
  assign activated = take;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_r <= 1'b0; // RULE5
      pend_r <= 1'b0;
      act_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      pend_r <= pend_nxt;
      act_r <= act_nxt;
    end
  end
endmodule

// ===== hdl/iep_regs.sv
// Memory-mapped enable, pending, active, priority and trigger bank for the interrupt lines
`timescale 1ns/1ps
`include "iep_map.svh"
module iep_regs #(
  parameter int LINES = 64,
  parameter int ID_W = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [`IEP_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  output logic regRvalid,
  input wire logic [LINES-1:0] irqSrc,
  input wire logic activateValid,
  input wire logic [ID_W-1:0] activateId,
  input wire logic exitValid,
  input wire logic [ID_W-1:0] exitId,
  output logic [LINES-1:0] irqEnabled,
  output logic [LINES-1:0] irqPending,
  output logic [LINES-1:0] irqActive,
  output logic [LINES-1:0] irqReady,
  output logic [LINES*`IEP_PRIO_W-1:0] irqPriority,
  output logic activateDone
);
  localparam int PRIO_WORDS = LINES / `IEP_PRIO_PER_WORD;
  localparam int PW_W = $clog2(PRIO_WORDS);

  // Address decode
  logic hiWord;
  logic [`IEP_ADDR_W-1:0] wordAddr;
  logic hitSetEn;
  logic hitClrEn;
  logic hitSetPend;
  logic hitClrPend;
  logic hitActive;
  logic hitPrio;
  logic hitTrig;
  logic [PW_W-1:0] prioIdx;
  iep_pkg::iep_region_type region;

  assign hiWord = regAddr[2];
  assign wordAddr = {regAddr[`IEP_ADDR_W-1:3], 3'h0};
  assign hitSetEn = (regAddr[1:0] == 2'h0) && (wordAddr == `IEP_OFF_SET_EN_LO); // RULE6
  assign hitClrEn = (regAddr[1:0] == 2'h0) && (wordAddr == `IEP_OFF_CLR_EN_LO); // RULE6
  assign hitSetPend = (regAddr[1:0] == 2'h0) && (wordAddr == `IEP_OFF_SET_PEND_LO); // RULE7
  assign hitClrPend = (regAddr[1:0] == 2'h0) && (wordAddr == `IEP_OFF_CLR_PEND_LO); // RULE7
  assign hitActive = (regAddr[1:0] == 2'h0) && (wordAddr == `IEP_OFF_ACTIVE_LO); // RULE8
  assign hitPrio = (regAddr[1:0] == 2'h0) && (regAddr >= `IEP_OFF_PRIO_FIRST)
    && (regAddr <= `IEP_OFF_PRIO_LAST); // RULE9
  assign hitTrig = (regAddr == `IEP_OFF_SOFT_TRIG); // RULE10
  assign prioIdx = PW_W'((regAddr - `IEP_OFF_PRIO_FIRST) >> 2);

  assign region = hitSetEn ? iep_pkg::IEP_REG_SET_EN :
    hitClrEn ? iep_pkg::IEP_REG_CLR_EN :
    hitSetPend ? iep_pkg::IEP_REG_SET_PEND :
    hitClrPend ? iep_pkg::IEP_REG_CLR_PEND :
    hitActive ? iep_pkg::IEP_REG_ACTIVE :
    hitPrio ? iep_pkg::IEP_REG_PRIO :
    hitTrig ? iep_pkg::IEP_REG_TRIG :
    iep_pkg::IEP_REG_NONE;

  // Write strobes spread over the 64 lines
  logic [LINES-1:0] wordMask;
  logic [LINES-1:0] wrBits;
  logic [LINES-1:0] enSetVec;
  logic [LINES-1:0] enClrVec;
  logic [LINES-1:0] pendSetVec;
  logic [LINES-1:0] pendClrVec;
  logic [LINES-1:0] trigVec;
  logic [LINES-1:0] activateVec;
  logic [LINES-1:0] exitVec;
  logic [LINES-1:0] takenVec;
  logic trigWrite;

  assign wordMask = hiWord ? {{32{1'b1}}, {(LINES-32){1'b0}}} :
    {{(LINES-32){1'b0}}, {32{1'b1}}}; // RULE14
  assign wrBits = {regWdata, regWdata} & wordMask; // RULE14
  assign enSetVec = (regWrite && region == iep_pkg::IEP_REG_SET_EN) ? wrBits : '0; // RULE1
  assign enClrVec = (regWrite && region == iep_pkg::IEP_REG_CLR_EN) ? wrBits : '0; // RULE3
  assign trigWrite = regWrite && region == iep_pkg::IEP_REG_TRIG;
  assign trigVec = trigWrite ? (LINES'(1) << regWdata[`IEP_TRIG_ID_W-1:0]) : '0; // RULE10
  assign pendSetVec = ((regWrite && region == iep_pkg::IEP_REG_SET_PEND) ? wrBits : '0)
    | trigVec; // RULE12
  assign pendClrVec = (regWrite && region == iep_pkg::IEP_REG_CLR_PEND) ? wrBits : '0; // RULE12
  assign activateVec = activateValid ? (LINES'(1) << activateId) : '0;
  assign exitVec = exitValid ? (LINES'(1) << exitId) : '0;

  // Per-line state
  for (genvar i = 0; i < LINES; i++) begin : g_line
    iep_line u_line (
      .core_clk(core_clk),
      .reset(reset),
      .srcLevel(irqSrc[i]),
      .enSet(enSetVec[i]),
      .enClr(enClrVec[i]),
      .pendSet(pendSetVec[i]),
      .pendClr(pendClrVec[i]),
      .activateReq(activateVec[i]),
      .exitReq(exitVec[i]),
      .enabled(irqEnabled[i]),
      .pending(irqPending[i]),
      .active(irqActive[i]),
      .activated(takenVec[i])
    );
  end

  assign irqReady = irqEnabled & irqPending & ~irqActive; // RULE11
  assign activateDone = |takenVec;

  // Priority storage, one byte per line, four lines per word
  logic [`IEP_PRIO_W-1:0] prio_r [LINES];
  logic prioWrite;

  assign prioWrite = regWrite && region == iep_pkg::IEP_REG_PRIO;

  for (genvar p = 0; p < LINES; p++) begin : g_prio
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        prio_r[p] <= '0; // RULE5
      end else if (prioWrite && prioIdx == PW_W'(p / `IEP_PRIO_PER_WORD)) begin
        prio_r[p] <= regWdata[(p % `IEP_PRIO_PER_WORD)*`IEP_PRIO_W +: `IEP_PRIO_W]; // RULE13
      end
    end
    assign irqPriority[p*`IEP_PRIO_W +: `IEP_PRIO_W] = prio_r[p];
  end

  // Software trigger holds the last requested line number
  logic [`IEP_TRIG_ID_W-1:0] trigId_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trigId_r <= '0; // RULE5
    end else if (trigWrite) begin
      trigId_r <= regWdata[`IEP_TRIG_ID_W-1:0]; // RULE10
    end
  end

  // Read data selection
  logic [31:0] enWord;
  logic [31:0] pendWord;
  logic [31:0] actWord;
  logic [31:0] prioWord;
  logic [31:0] rdSel;

  assign enWord = hiWord ? irqEnabled[LINES-1:32] : irqEnabled[31:0]; // RULE14
  assign pendWord = hiWord ? irqPending[LINES-1:32] : irqPending[31:0];
  assign actWord = hiWord ? irqActive[LINES-1:32] : irqActive[31:0];
  assign prioWord = {prio_r[{prioIdx, 2'h3}], prio_r[{prioIdx, 2'h2}],
    prio_r[{prioIdx, 2'h1}], prio_r[{prioIdx, 2'h0}]}; // RULE13

  always_comb begin
    case (region)
      iep_pkg::IEP_REG_SET_EN: begin
        rdSel = enWord; // RULE2
      end
      iep_pkg::IEP_REG_CLR_EN: begin
        rdSel = enWord; // RULE4
      end
      iep_pkg::IEP_REG_SET_PEND,
      iep_pkg::IEP_REG_CLR_PEND: begin
        rdSel = pendWord; // RULE12
      end
      iep_pkg::IEP_REG_ACTIVE: begin
        rdSel = actWord; // RULE8
      end
      iep_pkg::IEP_REG_PRIO: begin
        rdSel = prioWord; // RULE9
      end
      iep_pkg::IEP_REG_TRIG: begin
        rdSel = {{(32-`IEP_TRIG_ID_W){1'b0}}, trigId_r};
      end
      default: begin
        rdSel = `IEP_RESET_WORD;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdata <= `IEP_RESET_WORD; // RULE5
      regRvalid <= 1'b0;
    end else begin
      regRdata <= regRead ? rdSel : regRdata;
      regRvalid <= regRead;
    end
  end
endmodule

// ===== tb/iep_regs_monitor.sv
// Concurrent checks on the ports of the enable/pending bank
`timescale 1ns/1ps
module iep_regs_monitor #(
  parameter int LINES = 64,
  parameter int ID_W = 6
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regRvalid,
  input wire logic [LINES-1:0] irqSrc,
  input wire logic activateValid,
  input wire logic [ID_W-1:0] activateId,
  input wire logic [LINES-1:0] irqEnabled,
  input wire logic [LINES-1:0] irqPending,
  input wire logic [LINES-1:0] irqActive,
  input wire logic activateDone
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_setLo; regWrite && regAddr == 12'h000; endsequence
  sequence s_clrLo; regWrite && regAddr == 12'h080; endsequence
  property p_rst; $fell(reset) |-> (irqEnabled | irqPending | irqActive) == '0; endproperty
  property p_set; s_setLo |=> irqEnabled[31:0] == ($past(irqEnabled[31:0]) | $past(regWdata));
  endproperty
  property p_clr; s_clrLo |=> irqEnabled[31:0] == ($past(irqEnabled[31:0]) & ~$past(regWdata));
  endproperty
  property p_hold; !(regWrite && regAddr[11:8] == 4'h0) |=> $stable(irqEnabled); endproperty
  property p_rd; regRead |=> regRvalid; endproperty
  property p_nrd; !regRead |=> !regRvalid; endproperty
  property p_pend; |irqSrc |=> (irqPending & $past(irqSrc)) == $past(irqSrc); endproperty
  property p_act; activateDone |=> irqActive[$past(activateId)]; endproperty
  property p_ref; activateValid && !irqEnabled[activateId] |-> !activateDone; endproperty
  a_rst: assert property (p_rst) else $error("state not clear after reset");
  a_set: assert property (p_set) else $error("set-enable result wrong");
  a_clr: assert property (p_clr) else $error("clear-enable result wrong");
  a_hold: assert property (p_hold) else $error("enable changed without write");
  a_rd: assert property (p_rd) else $error("read not answered");
  a_nrd: assert property (p_nrd) else $error("answer without read");
  a_pend: assert property (p_pend) else $error("source did not set pending");
  a_act: assert property (p_act) else $error("accepted line not active");
  a_ref: assert property (p_ref) else $error("disabled line activated");
endmodule
bind iep_regs iep_regs_monitor #(.LINES(LINES), .ID_W(ID_W)) iep_regs_monitor_i (
  .core_clk(core_clk), .reset(reset), .regWrite(regWrite), .regRead(regRead),
  .regAddr(regAddr), .regWdata(regWdata), .regRvalid(regRvalid), .irqSrc(irqSrc),
  .activateValid(activateValid), .activateId(activateId), .irqEnabled(irqEnabled),
  .irqPending(irqPending), .irqActive(irqActive), .activateDone(activateDone));

// ===== tb/iep_core_model.sv
// Core side: offers the lowest pending line and returns on command
`timescale 1ns/1ps
module iep_core_model (
  input wire logic [63:0] irqPending,
  input wire logic takeEn,
  input wire logic exitCmd,
  input wire logic [5:0] exitLine,
  output logic activateValid,
  output logic [5:0] activateId,
  output logic exitValid,
  output logic [5:0] exitId
);
  always_comb begin
    activateId = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (irqPending[i]) begin
        activateId = 6'(i);
      end
    end
  end
  assign activateValid = takeEn && (|irqPending);
  assign exitValid = exitCmd;
  assign exitId = exitLine;
endmodule

// ===== tb/irq_enable_pending_regs_tb.sv
// Self-checking bench for the enable/pending bank
`timescale 1ns/1ps
module irq_enable_pending_regs_tb;
  logic core_clk = 0, reset = 1, regWrite = 0, regRead = 0, takeEn = 0, exitCmd = 0;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWdata = 32'h0, regRdata;
  logic regRvalid, activateValid, exitValid, activateDone;
  logic [5:0] activateId, exitId, exitLine = 6'h00;
  logic [63:0] irqSrc = 64'h0, irqEnabled, irqPending, irqActive, irqReady;
  logic [511:0] irqPriority;
  logic [11:0] offs[13] = '{12'h000, 12'h004, 12'h080, 12'h084, 12'h100, 12'h104,
    12'h180, 12'h184, 12'h200, 12'h204, 12'h300, 12'h33c, 12'he00};
  int failures = 0, num_checks = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  iep_regs iep_regs_i (.core_clk(core_clk), .reset(reset), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .irqSrc(irqSrc), .activateValid(activateValid),
    .activateId(activateId), .exitValid(exitValid), .exitId(exitId),
    .irqEnabled(irqEnabled), .irqPending(irqPending), .irqActive(irqActive),
    .irqReady(irqReady), .irqPriority(irqPriority), .activateDone(activateDone));
  iep_core_model iep_core_model_i (.irqPending(irqPending), .takeEn(takeEn),
    .exitCmd(exitCmd), .exitLine(exitLine), .activateValid(activateValid),
    .activateId(activateId), .exitValid(exitValid), .exitId(exitId));
  task automatic tally_and_finish;
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regWrite = 1;
    regAddr = a;
    regWdata = d;
    @(posedge core_clk);
    #1 regWrite = 0;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    regRead = 1;
    regAddr = a;
    @(posedge core_clk);
    #1 regRead = 0;
    chk("regRvalid", 64'h1, {63'h0, regRvalid});
    chk("regRdata", {32'h0, e}, {32'h0, regRdata});
    @(posedge core_clk);
    #1;
  endtask
  task automatic pulse(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    pulse(6);
    reset = 0;
    foreach (offs[k]) rd(offs[k], 32'h0);
    chk("irqState", 64'h0, irqEnabled | irqPending | irqActive);
    wr(12'h000, 32'h8000_0001);
    wr(12'h004, 32'h0000_0010);
    wr(12'h000, 32'h0);
    chk("irqEnabled", 64'h10_8000_0001, irqEnabled);
    rd(12'h004, 32'h10);
    rd(12'h080, 32'h8000_0001);
    wr(12'h080, 32'h1);
    wr(12'h084, 32'h0);
    rd(12'h000, 32'h8000_0000);
    wr(12'h010, 32'hffff_ffff);
    rd(12'h010, 32'h0);
    chk("irqEnabled", 64'h10_8000_0000, irqEnabled);
    irqSrc[2] = 1;
    takeEn = 1;
    pulse(1);
    irqSrc[2] = 0;
    chk("activateDone", 64'h0, {63'h0, activateDone});
    chk("irqReady", 64'h0, irqReady);
    pulse(1);
    takeEn = 0;
    chk("irqPending", 64'h4, irqPending);
    chk("irqActive", 64'h0, irqActive);
    wr(12'h180, 32'h4);
    wr(12'h104, 32'h10);
    rd(12'h104, 32'h10);
    chk("irqReady", 64'h10_0000_0000, irqReady);
    takeEn = 1;
    #1 chk("activateDone", 64'h1, {63'h0, activateDone});
    pulse(1);
    takeEn = 0;
    chk("irqReady", 64'h0, irqReady);
    rd(12'h204, 32'h10);
    wr(12'h104, 32'h10);
    rd(12'h184, 32'h10);
    wr(12'h184, 32'h10);
    rd(12'h184, 32'h0);
    wr(12'h204, 32'h0);
    rd(12'h204, 32'h10);
    exitLine = 6'h24;
    exitCmd = 1;
    pulse(1);
    exitCmd = 0;
    chk("irqActive", 64'h0, irqActive);
    wr(12'h300, 32'h1122_3344);
    wr(12'h33c, 32'h0000_00a5);
    rd(12'h300, 32'h1122_3344);
    chk("irqPriority", 64'h1122_3344, {32'h0, irqPriority[31:0]});
    chk("irqPriority", 64'ha5, {56'h0, irqPriority[487:480]});
    rd(12'h33c, 32'ha5);
    wr(12'he00, 32'h2d);
    chk("irqPending", 64'h2000_0000_0000, irqPending);
    rd(12'he00, 32'h2d);
    reset = 1;
    pulse(2);
    reset = 0;
    pulse(1);
    chk("irqState", 64'h0, irqEnabled | irqPending | irqActive);
    chk("irqPriority", 64'h0, {32'h0, irqPriority[31:0]});
    chk("regRdata", 64'h0, {32'h0, regRdata});
    rd(12'he00, 32'h0);
    tally_and_finish;
  end
endmodule
